// File: include/gpifd_regs.vh
`ifndef GPIFD_REGS_VH
`define GPIFD_REGS_VH
`define GPIFD_OFF_CFG 12'h000
`define GPIFD_OFF_NVM 12'h004
`define GPIFD_OFF_STAT 12'h008
`define GPIFD_OFF_CMD 12'h00c
`define GPIFD_CFG_CODE_LSB 0
`define GPIFD_CFG_CODE_MSB 3
`define GPIFD_CFG_CHSEL_LSB 4
`define GPIFD_CFG_CHSEL_MSB 5
`define GPIFD_CFG_SYNC_LSB 6
`define GPIFD_CFG_SYNC_MSB 7
`define GPIFD_CFG_PDN_LSB 8
`define GPIFD_CFG_PDN_MSB 11
`define GPIFD_CFG_RST 32'h00000000
`define GPIFD_FN_FAULT 4'h2
`define GPIFD_FN_CURRENT_OUTPUT 4'h3
`define GPIFD_FN_VOLTAGE_OUTPUT 4'h4
`define GPIFD_FN_PROT 4'h5
`define GPIFD_FN_CLR 4'h7
`define GPIFD_FN_LOAD 4'h8
`define GPIFD_FN_FGEN 4'h9
`define GPIFD_FN_MARG 4'ha
`define GPIFD_FN_RESET 4'hb
`define GPIFD_FN_NVM 4'hc
`define GPIFD_FN_WLOCK 4'hd
`define GPIFD_RESP_OKAY 2'b00
`define GPIFD_RESP_SLVERR 2'b10
`define GPIFD_RST_PULSE_CYC 4'h4
`endif

// File: hdl/gpifd_edge.v
`timescale 1ns/1ps
module gpifd_edge (
   aclk,
   aresetn,
   pin_in,
   level,
   fall,
   rise
);
   input wire aclk;
   input wire aresetn;
   input wire pin_in;
   output reg level;
   output wire fall;
   output wire rise;
   reg prev_reg;
   // pin is synchronous per system rule; two register stages give edge history
   always @(posedge aclk) begin
      if (!aresetn) begin
         prev_reg <= 1'b1;
         level <= 1'b1;
      end else begin
         prev_reg <= pin_in;
         level <= prev_reg;
      end
   end
   assign fall = level & ~prev_reg;
   assign rise = ~level & prev_reg;
endmodule

// File: hdl/gpifd_decoder.v
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`include "gpifd_regs.vh"
// Function
// - reset-input setting not saved in nvm is lost on any device reset
// - code 1011: low pulse resets the device on its rising edge; needs nvm copy
// - code 0100: fall powers down voltage_output per pulldown setting; rise powers up
// - code 1000: fall issues load strobe to channels with sync and select set
// - code 1101: falling edge allows register writes again
// - code 1101: rising edge blocks writes except to the cmd register unlock field
module gpifd_decoder (
   aclk,
   aresetn,
   gpio_in,
   awaddr,
   awvalid,
   awready,
   wdata,
   wstrb,
   wvalid,
   wready,
   bresp,
   bvalid,
   bready,
   araddr,
   arvalid,
   arready,
   rdata,
   rresp,
   rvalid,
   rready,
   device_reset_req,
   fault_dump_pulse,
   protect_pulse,
   clear_outputs_action,
   load_outputs_strobe,
   margin_low_pulse,
   margin_high_pulse,
   current_output_pdn,
   voltage_output_pdn,
   voltage_output_pulldown,
   fgen_run,
   nvm_prog_allowed,
   reg_write_blocked
);
   input wire aclk;
   input wire aresetn;
   input wire gpio_in;
   input wire [11:0] awaddr;
   input wire awvalid;
   output wire awready;
   input wire [31:0] wdata;
   input wire [3:0] wstrb;
   input wire wvalid;
   output wire wready;
   output reg [1:0] bresp;
   output reg bvalid;
   input wire bready;
   input wire [11:0] araddr;
   input wire arvalid;
   output wire arready;
   output reg [31:0] rdata;
   output reg [1:0] rresp;
   output reg rvalid;
   input wire rready;
   output reg device_reset_req;
   output reg fault_dump_pulse;
   output reg protect_pulse;
   output reg clear_outputs_action;
   output reg [1:0] load_outputs_strobe;
   output reg [1:0] margin_low_pulse;
   output reg [1:0] margin_high_pulse;
   output reg [1:0] current_output_pdn;
   output reg [1:0] voltage_output_pdn;
   output reg [3:0] voltage_output_pulldown;
   output reg [1:0] fgen_run;
   output reg nvm_prog_allowed;
   output reg reg_write_blocked;

   // volatile config, nvm image, and internal soft reset
   reg [11:0] cfg_reg;
   reg [11:0] nvm_reg;
   reg soft_rst_reg;
   reg [3:0] rst_cnt_reg;
   reg aw_hold_reg;
   reg w_hold_reg;
   reg [11:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;
   reg [7:0] fall_cnt_reg;
   reg [7:0] rise_cnt_reg;

   wire lvl;
   wire fall;
   wire rise;
   wire rst_all;
   wire [3:0] code;
   wire [1:0] chsel;
   wire [1:0] sync;
   wire do_write;
   wire unlock_write;
   wire wr_ok;

   assign rst_all = ~aresetn | soft_rst_reg;
   assign code = cfg_reg[`GPIFD_CFG_CODE_MSB:`GPIFD_CFG_CODE_LSB];
   assign chsel = cfg_reg[`GPIFD_CFG_CHSEL_MSB:`GPIFD_CFG_CHSEL_LSB];
   assign sync = cfg_reg[`GPIFD_CFG_SYNC_MSB:`GPIFD_CFG_SYNC_LSB];

   gpifd_edge u_edge (
      .aclk(aclk),
      .aresetn(aresetn),
      .pin_in(gpio_in),
      .level(lvl),
      .fall(fall),
      .rise(rise)
   );

   // write channel: address and data taken in either order
   assign awready = ~aw_hold_reg & ~bvalid;
   assign wready = ~w_hold_reg & ~bvalid;
   assign do_write = aw_hold_reg & w_hold_reg & ~bvalid;
   // any write to the cmd register address stands in for the unlock field, always writable
   assign unlock_write = (aw_addr_reg == `GPIFD_OFF_CMD);
   assign wr_ok = ~reg_write_blocked | unlock_write;

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         bvalid <= 1'b0;
         bresp <= `GPIFD_RESP_OKAY;
      end else begin
         if (awvalid && awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= awaddr;
         end
         if (wvalid && wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= wdata;
            w_strb_reg <= wstrb;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            bvalid <= 1'b1;
            if (aw_addr_reg == `GPIFD_OFF_CFG || aw_addr_reg == `GPIFD_OFF_NVM ||
                aw_addr_reg == `GPIFD_OFF_CMD)
               bresp <= wr_ok ? `GPIFD_RESP_OKAY : `GPIFD_RESP_SLVERR;
            else
               bresp <= `GPIFD_RESP_SLVERR;
         end else if (bvalid && bready) begin
            bvalid <= 1'b0;
         end
      end
   end

   // nvm image survives soft reset; volatile config does not
   always @(posedge aclk) begin
      if (!aresetn) begin
         nvm_reg <= 12'h000;
      end else if (do_write && wr_ok && aw_addr_reg == `GPIFD_OFF_NVM) begin
         if (w_strb_reg[0])
            nvm_reg[7:0] <= w_data_reg[7:0];
         if (w_strb_reg[1])
            nvm_reg[11:8] <= w_data_reg[11:8];
      end
   end

   always @(posedge aclk) begin
      if (rst_all) begin
         cfg_reg <= nvm_reg;
      end else if (do_write && wr_ok && aw_addr_reg == `GPIFD_OFF_CFG) begin
         if (w_strb_reg[0])
            cfg_reg[7:0] <= w_data_reg[7:0];
         if (w_strb_reg[1])
            cfg_reg[11:8] <= w_data_reg[11:8];
      end
   end

   // read channel, one cycle answer
   assign arready = ~rvalid;
   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= `GPIFD_RESP_OKAY;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= `GPIFD_RESP_OKAY;
         case (araddr)
            `GPIFD_OFF_CFG: rdata <= {20'h00000, cfg_reg};
            `GPIFD_OFF_NVM: rdata <= {20'h00000, nvm_reg};
            `GPIFD_OFF_STAT: rdata <= {rise_cnt_reg, fall_cnt_reg, 7'h00, lvl, fgen_run,
               current_output_pdn, voltage_output_pdn, nvm_prog_allowed, reg_write_blocked};
            `GPIFD_OFF_CMD: rdata <= 32'h00000000;
            default: begin
               rdata <= 32'h00000000;
               rresp <= `GPIFD_RESP_SLVERR;
            end
         endcase
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // reset mapping only honoured when the nvm image holds it too
   always @(posedge aclk) begin
      if (!aresetn) begin
         soft_rst_reg <= 1'b0;
         rst_cnt_reg <= 4'h0;
      end else begin
         soft_rst_reg <= 1'b0;
         if (code == `GPIFD_FN_RESET &&
             nvm_reg[`GPIFD_CFG_CODE_MSB:`GPIFD_CFG_CODE_LSB] == `GPIFD_FN_RESET) begin
            if (fall)
               rst_cnt_reg <= 4'h0;
            else if (!lvl && rst_cnt_reg != `GPIFD_RST_PULSE_CYC)
               rst_cnt_reg <= rst_cnt_reg + 4'h1;
            if (rise && rst_cnt_reg == `GPIFD_RST_PULSE_CYC)
               soft_rst_reg <= 1'b1;
         end else begin
            rst_cnt_reg <= 4'h0;
         end
      end
   end

   // action map
   always @(posedge aclk) begin
      if (rst_all) begin
         device_reset_req <= soft_rst_reg & aresetn; // must outlive the soft reset it reports
         fault_dump_pulse <= 1'b0;
         protect_pulse <= 1'b0;
         clear_outputs_action <= 1'b0;
         load_outputs_strobe <= 2'b00;
         margin_low_pulse <= 2'b00;
         margin_high_pulse <= 2'b00;
         current_output_pdn <= 2'b00;
         voltage_output_pdn <= 2'b00;
         voltage_output_pulldown <= 4'h0;
         fgen_run <= 2'b00;
         nvm_prog_allowed <= 1'b0;
         reg_write_blocked <= 1'b0;
         fall_cnt_reg <= 8'h00;
         rise_cnt_reg <= 8'h00;
      end else begin
         device_reset_req <= soft_rst_reg;
         fault_dump_pulse <= 1'b0;
         protect_pulse <= 1'b0;
         clear_outputs_action <= 1'b0;
         load_outputs_strobe <= 2'b00;
         margin_low_pulse <= 2'b00;
         margin_high_pulse <= 2'b00;
         if (fall)
            fall_cnt_reg <= fall_cnt_reg + 8'h01;
         if (rise)
            rise_cnt_reg <= rise_cnt_reg + 8'h01;
         case (code)
            `GPIFD_FN_FAULT: fault_dump_pulse <= fall;
            `GPIFD_FN_CURRENT_OUTPUT: begin
               if (fall)
                  current_output_pdn <= current_output_pdn | chsel;
               else if (rise)
                  current_output_pdn <= current_output_pdn & ~chsel;
            end
            `GPIFD_FN_VOLTAGE_OUTPUT: begin
               if (fall) begin
                  voltage_output_pdn <= voltage_output_pdn | chsel;
                  voltage_output_pulldown <= cfg_reg[`GPIFD_CFG_PDN_MSB:`GPIFD_CFG_PDN_LSB];
               end else if (rise) begin
                  voltage_output_pdn <= voltage_output_pdn & ~chsel;
               end
            end
            `GPIFD_FN_PROT: protect_pulse <= fall;
            `GPIFD_FN_CLR: clear_outputs_action <= fall;
            `GPIFD_FN_LOAD: load_outputs_strobe <= {2{fall}} & chsel & sync;
            `GPIFD_FN_FGEN: begin
               if (fall)
                  fgen_run <= fgen_run & ~chsel;
               else if (rise)
                  fgen_run <= fgen_run | chsel;
            end
            `GPIFD_FN_MARG: begin
               margin_low_pulse <= {2{fall}} & chsel;
               margin_high_pulse <= {2{rise}} & chsel;
            end
            `GPIFD_FN_NVM: begin
               if (fall)
                  nvm_prog_allowed <= 1'b1;
               else if (rise)
                  nvm_prog_allowed <= 1'b0;
            end
            `GPIFD_FN_WLOCK: begin
               if (fall)
                  reg_write_blocked <= 1'b0;
               else if (rise)
                  reg_write_blocked <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end
endmodule

// File: testbench/gpifd_pin_model.sv
`timescale 1ns/1ps
module gpifd_pin_model #(
   parameter int LAG = 2
) (
   input wire aclk,
   input wire want,
   output wire gpio_in
);
   // outside controller with a pull-up: idles high, follows each request a few cycles late
   logic [7:0] dly_reg = 8'hff;
   always @(posedge aclk) begin
      dly_reg <= {dly_reg[6:0], want};
   end
   assign gpio_in = dly_reg[LAG];
endmodule

// File: testbench/gpifd_chk_sva.sv
`timescale 1ns/1ps
module gpifd_chk (
   input wire aclk,
   input wire aresetn,
   input wire gpio_in,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire arvalid,
   input wire arready,
   input wire bvalid,
   input wire bready,
   input wire [1:0] bresp,
   input wire rvalid,
   input wire rready,
   input wire [31:0] rdata,
   input wire [1:0] load_outputs_strobe,
   input wire [1:0] margin_high_pulse,
   input wire [1:0] voltage_output_pdn,
   input wire reg_write_blocked
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   chk_b_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write answer dropped early");
   chk_r_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read answer dropped early");
   chk_aw_refuse: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while answer pending");
   chk_wr_answer: assert property (awvalid && awready && wvalid && wready |=> !bvalid ##1 bvalid)
      else $error("write answer late");
   chk_rd_answer: assert property (arvalid && arready |=> rvalid && !arready)
      else $error("read answer late");
   chk_load_fall: assert property (load_outputs_strobe != 2'h0 |-> !$past(gpio_in, 2))
      else $error("load strobe without falling pin");
   chk_margin_rise: assert property (margin_high_pulse != 2'h0 |-> $past(gpio_in, 2))
      else $error("margin high without rising pin");
   chk_voltage_output_fall: assert property ($rose(|voltage_output_pdn) |-> !$past(gpio_in, 2))
      else $error("power-down without falling pin");
   chk_block_rise: assert property ($rose(reg_write_blocked) |-> $past(gpio_in, 2))
      else $error("write block without rising pin");
endmodule
bind gpifd_decoder gpifd_chk i_gpifd_chk (.aclk, .aresetn, .gpio_in, .awvalid, .awready,
   .wvalid, .wready, .arvalid, .arready, .bvalid, .bready, .bresp, .rvalid, .rready,
   .rdata, .load_outputs_strobe, .margin_high_pulse, .voltage_output_pdn, .reg_write_blocked);

// File: testbench/gpio_input_function_decoder_test.sv
`timescale 1ns/1ps
`include "gpifd_regs.vh"
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin errors++; \
   $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module gpio_input_function_decoder_test;
   logic aclk = 0, aresetn = 0, want = 1, awvalid = 0, wvalid = 0, bready = 0;
   logic arvalid = 0, rready = 0;
   logic [11:0] awaddr = 12'h0, araddr = 12'h0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'hf;
   wire gpio_in, awready, wready, bvalid, arready, rvalid, device_reset_req, fault_dump_pulse;
   wire protect_pulse, clear_outputs_action, nvm_prog_allowed, reg_write_blocked;
   wire [1:0] bresp, rresp, load_outputs_strobe, margin_low_pulse, margin_high_pulse;
   wire [1:0] current_output_pdn, voltage_output_pdn, fgen_run;
   wire [3:0] voltage_output_pulldown;
   wire [31:0] rdata;
   logic [65:0] exp_q[$];
   int errors = 0, tests_run = 0, cyc = 0;
   int n[7];
   logic [3:0] code, pd;
   logic [1:0] ch, sync;
   logic [3:0] codes[10] = '{4'h2, 4'h3, 4'h4, 4'h5, 4'h7, 4'h8, 4'h9, 4'ha, 4'hc, 4'hd};
   gpifd_decoder i_gpifd_decoder (.aclk, .aresetn, .gpio_in, .awaddr, .awvalid, .awready,
      .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
      .arready, .rdata, .rresp, .rvalid, .rready, .device_reset_req, .fault_dump_pulse,
      .protect_pulse, .clear_outputs_action, .load_outputs_strobe, .margin_low_pulse,
      .margin_high_pulse, .current_output_pdn, .voltage_output_pdn, .voltage_output_pulldown, .fgen_run,
      .nvm_prog_allowed, .reg_write_blocked);
   gpifd_pin_model #(.LAG(3)) i_gpifd_pin_model (.aclk, .want, .gpio_in);
   initial forever #12.5 aclk = ~aclk;
   always @(posedge aclk) begin
      n[0] += $countones(load_outputs_strobe);
      n[1] += $countones(margin_low_pulse);
      n[2] += $countones(margin_high_pulse);
      n[3] += protect_pulse;
      n[4] += clear_outputs_action;
      n[5] += device_reset_req;
      n[6] += fault_dump_pulse;
      cyc++;
      if (cyc == 20000) begin
         errors++;
         finish_test();
      end
      if (bvalid && bready) chk_ans({bresp, 32'h0});
      if (rvalid && rready) chk_ans({rresp, rdata});
   end
   task chk_ans(input [33:0] got);
      logic [65:0] e;
      begin
         e = exp_q.pop_front();
         `CHK(got & {2'h3, e[63:32]}, {e[65:64], e[31:0]})
      end
   endtask
   task axi_wr(input [11:0] a, input [31:0] d, input [1:0] r);
      logic at, wt, bt;
      begin
         @(posedge aclk);
         exp_q.push_back({r, 32'h0, 32'h0});
         awaddr <= a;
         wdata <= d;
         awvalid <= 1'h1;
         wvalid <= 1'h1;
         bready <= 1'h1;
         bt = 0;
         while (!bt) begin
            @(negedge aclk);
            at = awvalid && awready;
            wt = wvalid && wready;
            bt = bvalid;
            @(posedge aclk);
            if (at) awvalid <= 1'h0;
            if (wt) wvalid <= 1'h0;
         end
         bready <= 1'h0;
      end
   endtask
   task axi_rd(input [11:0] a, input [31:0] d, input [31:0] m, input [1:0] r);
      logic at, bt;
      begin
         @(posedge aclk);
         exp_q.push_back({r, m, d & m});
         araddr <= a;
         arvalid <= 1'h1;
         rready <= 1'h1;
         bt = 0;
         while (!bt) begin
            @(negedge aclk);
            at = arvalid && arready;
            bt = rvalid;
            @(posedge aclk);
            if (at) arvalid <= 1'h0;
         end
         rready <= 1'h0;
      end
   endtask
   task pin(input v);
      begin
         @(posedge aclk);
         want <= v;
         repeat (12) @(posedge aclk);
      end
   endtask
   task finish_test;
      begin
         if (errors == 0 && tests_run > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   initial begin
      void'($urandom(83799));
      repeat (16) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(`GPIFD_OFF_CFG, `GPIFD_CFG_RST, 32'hfff, `GPIFD_RESP_OKAY);
      axi_rd(12'h010, 32'h0, 32'h0, `GPIFD_RESP_SLVERR);
      foreach (codes[i]) begin
         code = codes[i];
         ch = 2'($urandom_range(3, 1));
         sync = 2'($urandom);
         pd = 4'($urandom);
         // load needs at least one strobed channel or its checks prove nothing
         if (code == `GPIFD_FN_LOAD) begin
            ch = 2'h3;
            sync[0] = 1'b1;
         end
         axi_wr(`GPIFD_OFF_CFG, {20'h0, pd, sync, ch, code}, `GPIFD_RESP_OKAY);
         n = '{default: 0};
         pin(1'h0);
         case (code)
            `GPIFD_FN_CURRENT_OUTPUT: `CHK(current_output_pdn, ch)
            `GPIFD_FN_VOLTAGE_OUTPUT: `CHK({voltage_output_pdn, voltage_output_pulldown}, {ch, pd})
            `GPIFD_FN_FGEN: `CHK(fgen_run, 2'h0)
            `GPIFD_FN_NVM: `CHK(nvm_prog_allowed, 1'h1)
            `GPIFD_FN_WLOCK: `CHK(reg_write_blocked, 1'h0)
         endcase
         pin(1'h1);
         case (code)
            `GPIFD_FN_CURRENT_OUTPUT: `CHK(current_output_pdn, 2'h0)
            `GPIFD_FN_VOLTAGE_OUTPUT: `CHK(voltage_output_pdn, 2'h0)
            `GPIFD_FN_FGEN: `CHK(fgen_run, ch)
            `GPIFD_FN_NVM: `CHK(nvm_prog_allowed, 1'h0)
            `GPIFD_FN_WLOCK: `CHK(reg_write_blocked, 1'h1)
         endcase
         `CHK(n[0], code == `GPIFD_FN_LOAD ? $countones(sync) : 0)
         `CHK(n[1], code == `GPIFD_FN_MARG ? $countones(ch) : 0)
         `CHK(n[2], code == `GPIFD_FN_MARG ? $countones(ch) : 0)
         `CHK(n[3] + 2 * n[4], (code == `GPIFD_FN_PROT) + 2 * (code == `GPIFD_FN_CLR))
         `CHK(n[6], code == `GPIFD_FN_FAULT ? 1 : 0)
      end
      axi_wr(`GPIFD_OFF_CFG, 32'h0, `GPIFD_RESP_SLVERR);
      axi_wr(`GPIFD_OFF_CMD, 32'h1, `GPIFD_RESP_OKAY);
      axi_rd(`GPIFD_OFF_CFG, {20'h0, pd, sync, ch, 4'hd}, 32'hfff, `GPIFD_RESP_OKAY);
      pin(1'h0);
      `CHK(reg_write_blocked, 1'h0)
      // reset mapping held only in the working copy must not fire
      axi_wr(`GPIFD_OFF_CFG, 32'h03b, `GPIFD_RESP_OKAY);
      n = '{default: 0};
      pin(1'h1);
      `CHK(n[5], 0)
      axi_wr(`GPIFD_OFF_NVM, 32'h00b, `GPIFD_RESP_OKAY);
      pin(1'h0);
      pin(1'h1);
      `CHK(n[5], 1)
      axi_rd(`GPIFD_OFF_CFG, 32'h00b, 32'hfff, `GPIFD_RESP_OKAY);
      @(posedge aclk);
      aresetn <= 1'h0;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      axi_rd(`GPIFD_OFF_STAT, 32'h100, 32'h1ff, `GPIFD_RESP_OKAY);
      finish_test();
   end
endmodule
